/* design/lpm_pkg.sv */
package lpm_pkg;

  // Mode select encoding
  localparam logic MODE_STANDBY = 1'b0;
  localparam logic MODE_HALT    = 1'b1;

  // Clock rate and flush interval
  localparam int CLK_HZ           = 20_000_000;
  localparam int FLUSH_CYC        = 32;
  localparam int FLUSH_CYC_HALVED = 64;

  // Interval from IDLE to external clock out low, in system cycles
  localparam int XCLK_LOW_MIN_CYC = 32;
  localparam int XCLK_LOW_MAX_CYC = 45;

  // Wake qualification field
  localparam int QUAL_W      = 6;
  localparam int QUAL_BASE   = 2;

  // Resume latencies, system cycles
  localparam int RESUME_STBY_FAST_CYC = 100;
  localparam int RESUME_SLOW_CYC      = 1125;
  localparam int RESUME_HALT_RAM_CYC  = 35;
  // Chosen resume waits, kept well inside the limits
  localparam int RESUME_FAST_WAIT     = 16;
  localparam int RESUME_SLOW_WAIT     = 1000;

  // Lock interval in oscillator cycles
  localparam int PLL_LOCK_CYC = 131072;
  // Oscillator stabilisation wait, oscillator cycles
  localparam int OSC_STABLE_CYC = 1024;

  // Counter width
  localparam int CNT_W = 18;

endpackage : lpm_pkg

/* design/wake_qualifier.sv */
`timescale 1ns/1ps
// Synchronises the wake pin and qualifies it over (2 + count) cycles
module wake_qualifier #(
  parameter int QW = 6
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Raw pin and settings
  input  wire logic          wake_pin_n,
  input  wire logic          qual_en,
  input  wire logic [QW-1:0] qual_count,
  // Result
  output      logic          wake_valid,
  output      logic          wake_fall
);

  logic          sync1_q;
  logic          sync2_q;
  logic          prev_q;
  logic [QW:0]   run_q;
  logic [QW:0]   need;

  // Two flops before any logic sees the pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= wake_pin_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign need      = (QW+1)'(lpm_pkg::QUAL_BASE) + {1'b0, qual_count};
  assign wake_fall = prev_q & ~sync2_q;

  // Count low cycles; saturate so long pulses stay valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= '0;
    end else if (sync2_q) begin
      run_q <= '0;
    end else if (run_q != {(QW+1){1'b1}}) begin
      run_q <= run_q + (QW+1)'(1);
    end
  end

  // Without qualification any synchronised low counts
  // Compared against need minus one since the first synchronised low cycle counts as zero
  assign wake_valid = ~sync2_q & (~qual_en | (run_q >= need - (QW+1)'(1)));

endmodule : wake_qualifier

/* design/low_power_mode_sequencer.sv */
`timescale 1ns/1ps
module low_power_mode_sequencer #(
  parameter int LOCK_CYC   = lpm_pkg::PLL_LOCK_CYC,
  parameter int OSC_WAIT   = lpm_pkg::OSC_STABLE_CYC,
  parameter int SLOW_WAIT  = lpm_pkg::RESUME_SLOW_WAIT
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // CPU side
  input  wire logic                     idle_exec,
  input  wire logic                     mode_halt,
  input  wire logic                     input_clock_halve,
  input  wire logic                     flash_asleep,
  input  wire logic                     wake_int_en,
  input  wire logic                     crystal_source,
  output      logic                     cpu_resume,
  output      logic                     wake_irq,
  // Configuration (low_power_cfg_reg fields)
  input  wire logic                     qual_en,
  input  wire logic [lpm_pkg::QUAL_W-1:0] standby_wake_qual_count,
  // Wake pins
  input  wire logic                     wake_n,
  input  wire logic                     wake_gpio_n,
  // Clock gates and busy flag
  output      logic                     core_clk_en,
  output      logic                     periph_clk_en,
  output      logic                     pll_en,
  output      logic                     osc_en,
  output      logic                     wdog_clk_en,
  output      logic                     external_clock_out_en,
  output      logic                     lpm_active
);

  // Sequencer states; an unused code falls back to run
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_FLUSH  = 3'b001,
    ST_STBY   = 3'b010,
    ST_HALT   = 3'b011,
    ST_OSC    = 3'b100,
    ST_LOCK   = 3'b101,
    ST_RESUME = 3'b110
  } state_t;

  // Terminal counts, one less than the interval length
  localparam logic [lpm_pkg::CNT_W-1:0] FLUSH_N  =
    lpm_pkg::CNT_W'(lpm_pkg::FLUSH_CYC - 1);
  localparam logic [lpm_pkg::CNT_W-1:0] FLUSH_HN =
    lpm_pkg::CNT_W'(lpm_pkg::FLUSH_CYC_HALVED - 1);
  localparam logic [lpm_pkg::CNT_W-1:0] LOCK_N   = lpm_pkg::CNT_W'(LOCK_CYC - 1);
  localparam logic [lpm_pkg::CNT_W-1:0] OSC_N    = lpm_pkg::CNT_W'(OSC_WAIT - 1);
  localparam logic [lpm_pkg::CNT_W-1:0] FAST_N   =
    lpm_pkg::CNT_W'(lpm_pkg::RESUME_FAST_WAIT - 1);
  localparam logic [lpm_pkg::CNT_W-1:0] SLOW_N   = lpm_pkg::CNT_W'(SLOW_WAIT - 1);
  // Clock out drops this many cycles after idle, inside 32..45
  localparam logic [lpm_pkg::CNT_W-1:0] XCLK_N   =
    lpm_pkg::CNT_W'(lpm_pkg::XCLK_LOW_MIN_CYC + 2);

  // Sequencer state, counters, captured settings and helpers
  state_t                      state_q;
  state_t                      state_d;
  logic [lpm_pkg::CNT_W-1:0]   cnt_q;
  logic [lpm_pkg::CNT_W-1:0]   xcnt_q;
  logic                        halt_sel_q;
  logic                        halved_q;
  logic                        wake_valid;
  logic                        gpio_fall;
  logic                        cnt_done;
  logic [lpm_pkg::CNT_W-1:0]   flush_lim;
  logic [lpm_pkg::CNT_W-1:0]   resume_lim;
  logic                        run_clocks_d;
  logic                        pll_off_d;
  logic                        resume_done;

  // Standby wake pin, qualified
  wake_qualifier #(
    .QW (lpm_pkg::QUAL_W)
  ) u_stby_wake (
    .clk        (clk),
    .reset      (reset),
    .wake_pin_n (wake_n),
    .qual_en    (qual_en),
    .qual_count (standby_wake_qual_count),
    .wake_valid (wake_valid),
    .wake_fall  ()
  );

  // GPIO wake pin; only its edge matters
  wake_qualifier #(
    .QW (lpm_pkg::QUAL_W)
  ) u_gpio_wake (
    .clk        (clk),
    .reset      (reset),
    .wake_pin_n (wake_gpio_n),
    .qual_en    (1'b0),
    .qual_count ('0),
    .wake_valid (),
    .wake_fall  (gpio_fall)
  );

  // Flush length, resume wait and end of flush
  assign flush_lim  = halved_q ? FLUSH_HN : FLUSH_N;
  assign resume_lim = flash_asleep ? SLOW_N : FAST_N;
  assign cnt_done   = (cnt_q >= flush_lim);

  // Gates follow the next state, so every enable is a plain flop
  assign run_clocks_d = (state_d == ST_RUN || state_d == ST_FLUSH
                         || state_d == ST_RESUME);
  assign pll_off_d    = (state_d == ST_HALT || state_d == ST_OSC);

  // Last resume cycle, when the sequencer hands back to the CPU
  assign resume_done  = (state_q == ST_RESUME) && (state_d == ST_RUN);

  // Mode and clock halving captured at idle
  // A late change of the mode inputs cannot redirect a flush
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_sel_q <= lpm_pkg::MODE_STANDBY;
      halved_q   <= 1'b0;
    end else if (state_q == ST_RUN && idle_exec) begin
      halt_sel_q <= mode_halt;
      halved_q   <= input_clock_halve;
    end
  end

  // Next state
  // Each sleep state listens to its own wake source only
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (idle_exec) begin
          state_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (cnt_done) begin
          state_d = halt_sel_q ? ST_HALT : ST_STBY;
        end
      end
      ST_STBY: begin
        if (wake_valid) begin
          state_d = ST_RESUME;
        end
      end
      ST_HALT: begin
        if (gpio_fall) begin
          state_d = ST_OSC;
        end
      end
      ST_OSC: begin
        if (cnt_q >= OSC_N) begin
          state_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (cnt_q >= LOCK_N) begin
          state_d = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (cnt_q >= resume_lim) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State register
  // Block reset doubles as the reset-pin wake from halt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Interval counter, restarts on every state change
  // Held in the sleep states, so a long sleep cannot wrap it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (state_q != ST_RUN && state_q != ST_STBY && state_q != ST_HALT) begin
      cnt_q <= cnt_q + lpm_pkg::CNT_W'(1);
    end
  end

  // Clock out counter from idle; independent of flush length
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xcnt_q <= '0;
    end else if (state_q == ST_RUN) begin
      xcnt_q <= '0;
    end else if (xcnt_q != XCLK_N) begin
      xcnt_q <= xcnt_q + lpm_pkg::CNT_W'(1);
    end
  end

  // External clock out stops inside the allowed window
  // Fixed count from idle, so the flush length does not move it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      external_clock_out_en <= 1'b1;
    end else if (state_q == ST_RUN || state_d == ST_RUN) begin
      external_clock_out_en <= 1'b1;
    end else if (xcnt_q == XCLK_N - lpm_pkg::CNT_W'(1)) begin
      external_clock_out_en <= 1'b0;
    end
  end

  // Core clock runs through flush and resume, off while asleep
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_clk_en <= 1'b1;
    end else begin
      core_clk_en <= run_clocks_d;
    end
  end

  // Peripheral clocks stop in both sleep modes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periph_clk_en <= 1'b1;
    end else begin
      periph_clk_en <= run_clocks_d;
    end
  end

  // PLL stays down in halt and until the oscillator has settled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pll_en <= 1'b1;
    end else begin
      pll_en <= !pll_off_d;
    end
  end

  // Oscillator stops in halt only with a crystal source
  // An external clock source keeps running and needs no restart
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_en <= 1'b1;
    end else begin
      osc_en <= !(state_d == ST_HALT && crystal_source);
    end
  end

  // Watchdog keeps its clock in standby, loses it in halt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdog_clk_en <= 1'b1;
    end else begin
      wdog_clk_en <= !pll_off_d;
    end
  end

  // Resume pulse, one cycle, with the clocks already back
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_resume <= 1'b0;
    end else begin
      cpu_resume <= resume_done;
    end
  end

  // Wake interrupt only when enabled, never without a resume
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= resume_done && wake_int_en;
    end
  end

  // Busy flag from the idle edge until the sequencer is back in run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lpm_active <= 1'b0;
    end else begin
      lpm_active <= (state_d != ST_RUN);
    end
  end

endmodule : low_power_mode_sequencer

/* tb/lpm_properties.sv */
`timescale 1ns/1ps
// Port-level timing checks of the sequencer
module lpm_checker #(
  parameter int LOCK_CYC = 64
) (
  // Clock, reset, settings
  input wire logic clk,
  input wire logic reset,
  input wire logic input_clock_halve,
  input wire logic wake_int_en,
  input wire logic crystal_source,
  // Outputs watched
  input wire logic core_clk_en,
  input wire logic periph_clk_en,
  input wire logic pll_en,
  input wire logic osc_en,
  input wire logic wdog_clk_en,
  input wire logic external_clock_out_en,
  input wire logic lpm_active,
  input wire logic cpu_resume,
  input wire logic wake_irq
);
  // Upper bound leaves room for settle and resume waits
  localparam int HI = LOCK_CYC + 400;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  xclk_early_a: assert property ($fell(external_clock_out_en) |-> $past(lpm_active, 32))
    else $error("clock out low early");
  xclk_late_a: assert property ($rose(lpm_active) |-> ##[0:44] !external_clock_out_en)
    else $error("clock out low late");
  flush_time_a: assert property ($fell(core_clk_en) |->
    $past(lpm_active, 32) && (!input_clock_halve || $past(lpm_active, 64)))
    else $error("flush cut short");
  standby_keep_a: assert property ($fell(periph_clk_en) && pll_en |->
    wdog_clk_en && !core_clk_en)
    else $error("standby gating wrong");
  halt_off_a: assert property (!pll_en |-> !periph_clk_en && !core_clk_en)
    else $error("pll off with clocks on");
  osc_off_a: assert property (!osc_en |-> crystal_source && !core_clk_en)
    else $error("oscillator off wrongly");
  lock_wait_a: assert property ($rose(osc_en) |-> ##[LOCK_CYC:HI] $rose(core_clk_en))
    else $error("lock interval wrong");
  irq_gate_a: assert property (wake_irq |-> wake_int_en && cpu_resume)
    else $error("wake irq not allowed");
  resume_clk_a: assert property (cpu_resume |-> core_clk_en && periph_clk_en)
    else $error("resume with clocks off");
endmodule : lpm_checker
bind low_power_mode_sequencer lpm_checker #(.LOCK_CYC(LOCK_CYC)) i_lpm_checker (.*);

/* tb/wake_source.sv */
`timescale 1ns/1ps
// External wake source; both lines idle high on pull-ups
module wake_source (
  // Clock
  input  wire logic clk,
  // Wake lines
  output      logic wake_n,
  output      logic wake_gpio_n
);
  // Released lines sit at the pull-up level
  initial begin
    wake_n      = 1'h1;
    wake_gpio_n = 1'h1;
  end
  // Caller sizes len; a pulse that is too short is simply missed
  task automatic pulse(input logic gpio, input int len);
    @(negedge clk);
    if (gpio) wake_gpio_n = 1'h0;
    else wake_n = 1'h0;
    repeat (len) @(negedge clk);
    {wake_n, wake_gpio_n} = 2'h3;
  endtask : pulse
endmodule : wake_source

/* tb/test_low_power_mode_sequencer.sv */
`timescale 1ns/1ps
// Self-checking bench for the low-power sequencer
module test_low_power_mode_sequencer;
  // Short lock and settle counts keep the run brief
  localparam int LOCK = 64;
  localparam int OSC  = 8;
  // Settings, expected pll and oscillator state while asleep, then qualification count
  typedef struct packed {
    logic       halt, halve, flash, ien, xtal, qen, pll_exp, osc_exp;
    logic [5:0] q;
  } row_t;
  row_t rows[5] = '{14'h05C0, 14'h1BFF, 14'h06C5, 14'h2600, 14'h3840};
  logic clk, reset, idle_exec, mode_halt, input_clock_halve, flash_asleep, qual_en;
  logic wake_int_en, crystal_source, cpu_resume, wake_irq, wake_n, wake_gpio_n;
  logic core_clk_en, periph_clk_en, pll_en, osc_en, wdog_clk_en, lpm_active;
  logic external_clock_out_en;
  logic [lpm_pkg::QUAL_W-1:0] standby_wake_qual_count;
  int mismatches = 0, total_checks = 0, n;
  low_power_mode_sequencer #(.LOCK_CYC(LOCK), .OSC_WAIT(OSC), .SLOW_WAIT(20))
    i_low_power_mode_sequencer (.*);
  wake_source i_wake_source (.*);
  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic idle_pulse;
    @(negedge clk);
    idle_exec = 1'h1;
    @(negedge clk);
    idle_exec = 1'h0;
  endtask : idle_pulse
  // Enter a mode, check the gating, wake up and check the resume
  task automatic run_row(input row_t r);
    int len, f, lim;
    len = r.halt ? OSC + 4 : (r.qen ? int'(r.q) + 6 : 5);
    f = r.halve ? lpm_pkg::FLUSH_CYC_HALVED : lpm_pkg::FLUSH_CYC;
    {mode_halt, input_clock_halve, flash_asleep} = {r.halt, r.halve, r.flash};
    {wake_int_en, crystal_source, qual_en} = {r.ien, r.xtal, r.qen};
    standby_wake_qual_count = r.q;
    idle_pulse();
    mode_halt = ~r.halt; // Late change must not count
    n = 0;
    while (external_clock_out_en === 1'h1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n >= lpm_pkg::XCLK_LOW_MIN_CYC && n <= lpm_pkg::XCLK_LOW_MAX_CYC, 1'h1);
    while (core_clk_en === 1'h1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    chk(n >= f && n <= f + 2, 1'h1);
    idle_pulse(); // Ignored while asleep
    chk({periph_clk_en, lpm_active}, 2'h1);
    chk(pll_en, r.pll_exp);
    chk(osc_en, r.osc_exp);
    chk(wdog_clk_en | r.halt, 1'h1);
    lim = r.flash ? lpm_pkg::RESUME_SLOW_CYC : lpm_pkg::RESUME_STBY_FAST_CYC;
    if (r.halt) lim = LOCK + OSC + 8 + (r.flash ? lim : lpm_pkg::RESUME_HALT_RAM_CYC);
    else lim = lim + len;
    n = 0;
    fork
      i_wake_source.pulse(r.halt, len);
      begin
        while (cpu_resume !== 1'h1 && n < 1300) begin
          @(posedge clk);
          #1;
          n++;
        end
        chk(wake_irq, r.ien);
        chk(core_clk_en & periph_clk_en, 1'h1);
      end
    join
    chk(n <= lim, 1'h1);
    chk(!r.halt || n >= LOCK, 1'h1);
    repeat (2) @(negedge clk);
    chk(lpm_active, 1'h0);
  endtask : run_row
  // Reset, table rows, then halt left only through reset
  initial begin
    {reset, idle_exec, mode_halt, input_clock_halve, flash_asleep} = 5'h10;
    {wake_int_en, crystal_source, qual_en} = 3'h0;
    standby_wake_qual_count = 6'h00;
    repeat (2) @(negedge clk);
    chk({core_clk_en, periph_clk_en, pll_en, osc_en, wdog_clk_en}, 5'h1F);
    chk({external_clock_out_en, lpm_active, cpu_resume, wake_irq}, 4'h8);
    reset = 1'h0;
    foreach (rows[i]) run_row(rows[i]);
    mode_halt = 1'h1;
    idle_pulse();
    repeat (80) @(negedge clk);
    i_wake_source.pulse(1'h0, 8);
    repeat (40) @(negedge clk);
    chk({core_clk_en, lpm_active}, 2'h1);
    reset = 1'h1;
    repeat (OSC + 8) @(negedge clk);
    chk({core_clk_en, periph_clk_en, pll_en, osc_en, lpm_active}, 5'h1E);
    reset = 1'h0;
    repeat (2) @(negedge clk);
    chk({core_clk_en, lpm_active, cpu_resume}, 3'h4);
    end_of_test();
  end
  // Whole run needs well under this span
  initial begin
    #(50 * 20000);
    mismatches++;
    end_of_test();
  end
endmodule : test_low_power_mode_sequencer
